// ===== include/pfd_regs.vh
`ifndef PFD_REGS_VH
`define PFD_REGS_VH
// divide ratio from vco to detector
`define PFD_DIV_RATIO      256
`define PFD_DIV_WIDTH      8
// clock rate and lowest external reference
`define PFD_CLK_MHZ        100
`define PFD_REF_MIN_MHZ    2
`define PFD_VCO_MIN_MHZ    512
// longest reference period in clocks, rounded up
`define PFD_REF_MAX_CYC    ((`PFD_CLK_MHZ + `PFD_REF_MIN_MHZ - 1) / `PFD_REF_MIN_MHZ)
// pump encodings
`define PFD_PUMP_IDLE      2'h0
`define PFD_PUMP_UP        2'h1
`define PFD_PUMP_DN        2'h2
// output levels while reset is low
`define PFD_OSC_DRIVE_RST  1'b1
`define PFD_PUMP_OUT_RST   1'b0
`define PFD_PUMP_OE_N_RST  1'b1
`define PFD_QUIET_RST      1'b1
`endif

// ===== src/pfd_vco_divider.v
`timescale 1ns/1ns
`default_nettype none
`include "pfd_regs.vh"
module pfd_vco_divider #(
    parameter WIDTH = `PFD_DIV_WIDTH
) (
    input  wire mclk,
    input  wire reset_n,
    input  wire vco_rise,
    output reg  divided_vco_edge
);
    reg [WIDTH-1:0] count_q;

    // one pulse per 2**WIDTH vco rising edges
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_q          <= {WIDTH{1'b0}};
            divided_vco_edge <= 1'b0;
        end else begin
            divided_vco_edge <= 1'b0;
            if (vco_rise) begin
                count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
                if (count_q == {WIDTH{1'b1}}) begin
                    divided_vco_edge <= 1'b1;
                end
            end
        end
    end
endmodule // pfd_vco_divider
`default_nettype wire

// ===== src/pfd_detector.v
`timescale 1ns/1ns
`default_nettype none
`include "pfd_regs.vh"
module pfd_detector #(
    parameter DIV_WIDTH = `PFD_DIV_WIDTH
) (
    input  wire mclk,
    input  wire reset_n,
    input  wire reference_input_pin,
    input  wire vco_input_pin,
    output reg  oscillator_drive_pin,
    output reg  detector_pump_pin_out,
    output reg  detector_pump_pin_oe_n,
    output reg  lock_quiet
);
    // one synchroniser lane per pin
    localparam PIN_COUNT = 2;
    localparam REF_LANE  = 0;
    localparam VCO_LANE  = 1;

    // pump states, at most one direction at a time
    localparam [1:0] ST_IDLE = `PFD_PUMP_IDLE;
    localparam [1:0] ST_UP   = `PFD_PUMP_UP;
    localparam [1:0] ST_DN   = `PFD_PUMP_DN;

    // levels held while reset is low
    localparam OSC_DRIVE_RST = `PFD_OSC_DRIVE_RST;
    localparam PUMP_OUT_RST  = `PFD_PUMP_OUT_RST;
    localparam PUMP_OE_N_RST = `PFD_PUMP_OE_N_RST;
    localparam QUIET_RST     = `PFD_QUIET_RST;

    wire [PIN_COUNT-1:0] lane_pin;
    wire [PIN_COUNT-1:0] lane_level;
    wire [PIN_COUNT-1:0] lane_rise;
    wire                 reference_level;
    wire                 reference_edge;
    wire                 vco_rise;
    wire                 divided_vco_edge;
    wire                 edge_together;
    reg  [1:0]           pump_q;
    reg  [1:0]           pump_d;
    reg                  pump_out_d;
    reg                  pump_oe_n_d;
    reg                  quiet_d;
    reg                  osc_drive_d;

    // a rising edge is high now and low one sample ago
    function level_rose;
        input now_level;
        input last_level;
        begin
            level_rose = now_level & ~last_level;
        end
    endfunction

    // the pump drives the pin whenever it sources or sinks
    function pump_driving;
        input [1:0] state;
        begin
            pump_driving = (state == ST_UP) || (state == ST_DN);
        end
    endfunction

    // pin order inside the lanes
    assign lane_pin[REF_LANE] = reference_input_pin;
    assign lane_pin[VCO_LANE] = vco_input_pin;

    // two flip-flops per pin, a third for the edge; no enable anywhere
    genvar lane;
    generate
        for (lane = 0; lane < PIN_COUNT; lane = lane + 1) begin : g_lane
            reg s1_q;
            reg s2_q;
            reg prev_q;

            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    s1_q   <= 1'b0;
                    s2_q   <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    s1_q   <= lane_pin[lane];
                    s2_q   <= s1_q;
                    prev_q <= s2_q;
                end
            end

            assign lane_level[lane] = s2_q;
            assign lane_rise[lane]  = level_rose(s2_q, prev_q);
        end
    endgenerate

    assign reference_level = lane_level[REF_LANE];
    assign reference_edge  = lane_rise[REF_LANE];
    assign vco_rise        = lane_rise[VCO_LANE];
    assign edge_together   = reference_edge & divided_vco_edge;

    // prescaler ahead of the comparison
    pfd_vco_divider #(
        .WIDTH (DIV_WIDTH)
    ) u_div (
        .mclk             (mclk),
        .reset_n          (reset_n),
        .vco_rise         (vco_rise),
        .divided_vco_edge (divided_vco_edge)
    );

    // three-state detector: first edge opens a pulse, the other edge closes it
    always @* begin
        pump_d = pump_q;
        case (pump_q)
            ST_IDLE: begin
                if (edge_together) begin
                    pump_d = ST_IDLE;
                end else if (reference_edge) begin
                    pump_d = ST_UP;
                end else if (divided_vco_edge) begin
                    pump_d = ST_DN;
                end else begin
                    pump_d = ST_IDLE;
                end
            end
            ST_UP: begin
                if (divided_vco_edge) begin
                    pump_d = ST_IDLE;
                end else begin
                    pump_d = ST_UP;
                end
            end
            ST_DN: begin
                if (reference_edge) begin
                    pump_d = ST_IDLE;
                end else begin
                    pump_d = ST_DN;
                end
            end
            default: begin
                pump_d = ST_IDLE;
            end
        endcase
    end

    // pin level for the next state
    always @* begin
        pump_out_d = (pump_d == ST_UP);
    end

    // released whenever nothing is pending
    always @* begin
        pump_oe_n_d = ~pump_driving(pump_d);
    end

    always @* begin
        quiet_d = ~pump_driving(pump_d);
    end

    // inverted side of the reference buffer
    always @* begin
        osc_drive_d = ~reference_level;
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pump_q <= ST_IDLE;
        end else begin
            pump_q <= pump_d;
        end
    end

    // every output straight from a flip-flop
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            oscillator_drive_pin <= OSC_DRIVE_RST;
        end else begin
            oscillator_drive_pin <= osc_drive_d;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            detector_pump_pin_out <= PUMP_OUT_RST;
        end else begin
            detector_pump_pin_out <= pump_out_d;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            detector_pump_pin_oe_n <= PUMP_OE_N_RST;
        end else begin
            detector_pump_pin_oe_n <= pump_oe_n_d;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lock_quiet <= QUIET_RST;
        end else begin
            lock_quiet <= quiet_d;
        end
    end
endmodule // pfd_detector
`default_nettype wire

// ===== tb/pfd_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pfd_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reference_input_pin,
    input wire logic oscillator_drive_pin,
    input wire logic detector_pump_pin_out,
    input wire logic detector_pump_pin_oe_n,
    input wire logic lock_quiet
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire src = !detector_pump_pin_oe_n && detector_pump_pin_out;
    wire snk = !detector_pump_pin_oe_n && !detector_pump_pin_out;
    sequence ref_up; $rose(reference_input_pin); endsequence
    src_start_a: assert property (ref_up ##0 lock_quiet |-> ##[2:4] src) else $error("src");
    quiet_idle_a: assert property (lock_quiet == detector_pump_pin_oe_n) else $error("qt");
    osc_inv_a: assert property (ref_up |-> ##[1:4] !oscillator_drive_pin) else $error("osc");
    snk_flip_a: assert property (snk |=> !src) else $error("flip");
    src_flip_a: assert property (src |=> !snk) else $error("flip");
    snk_hold_a: assert property (snk && !reference_input_pin |=> snk) else $error("hold");
    src_absorb_a: assert property (src ##0 ref_up |=> src [*4]) else $error("abs");
    sink_end_a: assert property ($rose(detector_pump_pin_oe_n) ##0 $past(snk)
        |-> $past(reference_input_pin, 2)) else $error("end");
endmodule // pfd_checker
bind pfd_detector pfd_checker chk (.mclk(mclk), .reset_n(reset_n),
    .reference_input_pin(reference_input_pin), .oscillator_drive_pin(oscillator_drive_pin),
    .detector_pump_pin_out(detector_pump_pin_out), .lock_quiet(lock_quiet),
    .detector_pump_pin_oe_n(detector_pump_pin_oe_n));
`default_nettype wire

// ===== tb/pfd_vco_model.sv
`timescale 1ns/1ns
`default_nettype none
module pfd_vco_model (
    input  wire logic [7:0] half_ns,
    output var  logic       vco
);
    // tuning held by the filter is set through half_ns
    initial vco = 1'b0;
    always #(half_ns) vco = !vco;
endmodule // pfd_vco_model
`default_nettype wire

// ===== tb/pfd_detector_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pfd_detector_tb;
    logic mclk = 1'b0, reset_n = 1'b0, ref_in = 1'b0;
    logic [7:0] half = 8'h3c;
    wire vco, out, oe_n, quiet, osc;
    int err_total = 0, compares = 0;
    always #5 mclk = !mclk;
    pfd_vco_model vm (.half_ns(half), .vco(vco));
    pfd_detector dut (.mclk(mclk), .reset_n(reset_n), .reference_input_pin(ref_in),
        .vco_input_pin(vco), .oscillator_drive_pin(osc), .detector_pump_pin_out(out),
        .detector_pump_pin_oe_n(oe_n), .lock_quiet(quiet));
    task chk(input string n, input logic [1:0] e, input logic [1:0] g);
        compares++;
        if (e !== g) begin
            err_total++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task rst;
        reset_n = 1'b0;
        ref_in = 1'b0;
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
    endtask
    task wait_oe(input logic v);
        for (int i = 0; i < 4000 && oe_n !== v; i++) @(negedge mclk);
        chk("wait", {1'b0, v}, {1'b0, oe_n});
    endtask
    task t_lead;
        half = 8'h3c;
        rst;
        chk("idle", 2'h3, {oe_n, quiet});
        ref_in = 1'b1;
        repeat (6) @(negedge mclk);
        chk("src", 2'h1, {oe_n, out});
        chk("osc", 2'h0, {1'b0, osc});
        ref_in = 1'b0;
        repeat (3) @(negedge mclk);
        ref_in = 1'b1;
        repeat (1000) @(negedge mclk);
        chk("hold", 2'h1, {oe_n, out});
        wait_oe(1'b1);
    endtask
    task t_lag;
        half = 8'h28;
        rst;
        wait_oe(1'b0);
        chk("snk", 2'h0, {oe_n, out});
        ref_in = 1'b1;
        repeat (6) @(negedge mclk);
        chk("clr", 2'h3, {oe_n, quiet});
    endtask
    task final_report;
        if (err_total == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        final_report;
    end
    initial begin
        t_lead;
        t_lag;
        final_report;
    end
endmodule // pfd_detector_tb
`default_nettype wire
